/* mst_params.svh */
// timing counts, positions and step increments of the microstep translator
`ifndef MST_PARAMS_SVH
`define MST_PARAMS_SVH

`define MST_CLK_NS        50
`define MST_HOME_POS      6'h08
`define MST_INC_FULL      6'h10
`define MST_INC_HALF      6'h08
`define MST_INC_QUARTER   6'h04
`define MST_INC_SIXTEENTH 6'h01
`define MST_LEVEL_MAX     5'h10

`define MST_RT_KOHM       56
`define MST_CT_PF         680
`define MST_BLANK_FACTOR  1400
`define MST_BLANK_NS      ((`MST_BLANK_FACTOR * `MST_CT_PF) / 1000)
`define MST_BLANK_CYC     ((`MST_BLANK_NS + `MST_CLK_NS - 1) / `MST_CLK_NS)
`define MST_OFF_NS        (`MST_RT_KOHM * `MST_CT_PF)
`define MST_OFF_CYC       (`MST_OFF_NS / `MST_CLK_NS)

`define MST_OC_BLANK_NS   1500
`define MST_OC_BLANK_CYC  (`MST_OC_BLANK_NS / `MST_CLK_NS)
`define MST_OC_LATCH_NS   1600000
`define MST_OC_LATCH_CYC  (`MST_OC_LATCH_NS / `MST_CLK_NS)

`endif

/* mst_pkg.sv */
// types shared by the microstep translator and its phase regulators
package mst_pkg;
  typedef enum logic [1:0] {
    DECAY_SLOW  = 2'h0,
    DECAY_FAST  = 2'h1,
    DECAY_MIXED = 2'h2
  } mst_decay_t;

  typedef enum logic [3:0] {
    PH_OFF  = 4'h1,
    PH_ON   = 4'h2,
    PH_FAST = 4'h4,
    PH_SLOW = 4'h8
  } mst_phase_state_t;
endpackage

/* mst_sync2.sv */
// two-flop synchroniser for a vector of unrelated pin levels
`timescale 1ns/1ps
module mst_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* mst_phase_reg.sv */
// fixed off-time pwm regulator of one full bridge with blanking and mixed decay
`timescale 1ns/1ps
`include "mst_params.svh"
module mst_phase_reg import mst_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  mst_decay_t      decay,
  input  wire logic       trip,
  input  wire logic       node_at_pfd,
  input  wire logic       cur_zero,
  input  wire logic       assist_off,
  output logic            src_on_r,
  output logic            snk_on_r,
  output logic            recirc_on_r
);
  mst_phase_state_t state_r, state_nxt;
  logic [4:0]       blank_r;
  logic [9:0]       off_r;
  logic             trip_seen;

  // trip only counts once the switching transient has died away
  assign trip_seen = trip && (blank_r == 5'h00);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PH_OFF:  if (enable) state_nxt = PH_ON;
      PH_ON:   if (trip_seen) state_nxt = (decay == DECAY_SLOW) ? PH_SLOW : PH_FAST;
      PH_FAST: begin
        if (off_r == 10'h000) state_nxt = PH_ON;
        else if (decay == DECAY_MIXED && node_at_pfd) state_nxt = PH_SLOW;
      end
      PH_SLOW: if (off_r == 10'h000) state_nxt = PH_ON;
      default: state_nxt = PH_OFF;
    endcase
    if (!enable) state_nxt = PH_OFF;
  end

  always_ff @(posedge clk) begin
    if (rst) state_r <= PH_OFF;
    else     state_r <= state_nxt;
  end

  always_ff @(posedge clk) begin
    if (rst) blank_r <= 5'h00;
    else if (state_nxt != state_r) blank_r <= 5'(`MST_BLANK_CYC) - 5'h01;
    else if (blank_r != 5'h00) blank_r <= blank_r - 5'h01;
  end

  always_ff @(posedge clk) begin
    if (rst) off_r <= 10'h000;
    else if (state_r == PH_ON && state_nxt != PH_ON) off_r <= 10'(`MST_OFF_CYC) - 10'h001;
    else if (off_r != 10'h000) off_r <= off_r - 10'h001;
  end

  // slow decay keeps the sink on; fast decay drops both sides
  always_ff @(posedge clk) begin
    if (rst) begin
      src_on_r    <= 1'b0;
      snk_on_r    <= 1'b0;
      recirc_on_r <= 1'b0;
    end else begin
      src_on_r    <= (state_nxt == PH_ON);
      snk_on_r    <= (state_nxt == PH_ON) || (state_nxt == PH_SLOW);
      recirc_on_r <= (state_nxt == PH_FAST || state_nxt == PH_SLOW) && !assist_off && !cur_zero;
    end
  end

  sequence s_trip;
    enable && state_r == PH_ON && trip_seen;
  endsequence

  a_trip_drive: assert property (@(posedge clk) disable iff (rst)
    s_trip |=> !src_on_r && (snk_on_r == ($past(decay) == DECAY_SLOW)))
    else $error("trip did not switch the drivers as the decay mode asks");
  a_blank_hold: assert property (@(posedge clk) disable iff (rst)
    enable && state_r == PH_ON && blank_r != 5'h00 |=> state_r == PH_ON)
    else $error("comparator acted inside the blanking interval");
  a_off_time: assert property (@(posedge clk) disable iff (rst)
    s_trip |=> off_r == 10'(`MST_OFF_CYC) - 10'h001)
    else $error("off-time not started at its full length");
  a_off_end: assert property (@(posedge clk) disable iff (rst)
    enable && (state_r == PH_SLOW) && off_r == 10'h000 |=> src_on_r && snk_on_r)
    else $error("drivers not re-enabled when the off-time ended");
  a_mixed_slow: assert property (@(posedge clk) disable iff (rst)
    enable && state_r == PH_FAST && decay == DECAY_MIXED && node_at_pfd && off_r != 10'h000
    |=> state_r == PH_SLOW && snk_on_r && !src_on_r)
    else $error("mixed decay did not fall back to slow decay");
  a_assist_off: assert property (@(posedge clk) disable iff (rst)
    assist_off |=> !recirc_on_r)
    else $error("recirculation on while assistance is disabled");
endmodule

/* mst_translator.sv */
// step/direction translator with decay selection, protection and two phase regulators
`timescale 1ns/1ps
`include "mst_params.svh"
// Contract
// - reset homes position, decay mixed both phases
// - each step rising edge outside clear, lockout, wake and sleep moves one increment
// - select pins choose full/half/quarter/sixteenth
// - resolution sampled only at step edge
// - direction level picks forward or backward
// - rising or equal level uses slow decay
// - falling level uses selected decay mode
// - decay select decodes slow, fast, mixed
// - trip clears latch, drivers off per mode
// - off-time one-shot then diagonal re-enabled
// - comparator ignored during blanking after switching
// - mixed: fast until node reaches level
// - clear holds home, outputs off, steps ignored
// - origin indicator low only at home
// - recirculation assist unless disabled, stops at zero
// - enable gates outputs, translator still steps
// - sleep disables; wake edge returns home
// - temperature or supply faults disable outputs
// - supply lockout disables drivers, homes translator
// - sustained overcurrent latches outputs off 1.6 ms
// - overcurrent blanked for 1.5 us first
// - home is 45 degrees, both positive
module mst_translator import mst_pkg::*; #(
  parameter int OC_LATCH_CYC = `MST_OC_LATCH_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       STEP,
  input  wire logic       DIR,
  input  wire logic       RESOLUTION_SEL_LO,
  input  wire logic       RESOLUTION_SEL_HI,
  input  wire logic       DECAY_SEL_ABOVE_HI,
  input  wire logic       DECAY_SEL_BELOW_LO,
  input  wire logic       TRANSLATOR_CLEAR_N,
  input  wire logic       OUTPUTS_ON_N,
  input  wire logic       LOW_POWER_N,
  input  wire logic       RECIRC_ASSIST_OFF,
  input  wire logic       THERMAL_FAULT,
  input  wire logic       GATE_PUMP_SUPPLY_LOW,
  input  wire logic       SINK_GATE_SUPPLY_LOW,
  input  wire logic       SUPPLY_LOW_LOCKOUT,
  input  wire logic       OVERCURRENT_SENSE,
  input  wire logic       P1_TRIP,
  input  wire logic       P2_TRIP,
  input  wire logic       P1_TIMING_NODE_AT_PFD,
  input  wire logic       P2_TIMING_NODE_AT_PFD,
  input  wire logic       P1_CURRENT_ZERO,
  input  wire logic       P2_CURRENT_ZERO,
  output logic            AT_ORIGIN_N,
  output logic [4:0]      P1_LEVEL,
  output logic            P1_POSITIVE,
  output logic [4:0]      P2_LEVEL,
  output logic            P2_POSITIVE,
  output mst_decay_t      P1_DECAY,
  output mst_decay_t      P2_DECAY,
  output logic            P1_SOURCE_ON,
  output logic            P1_SINK_ON,
  output logic            P1_RECIRC_ON,
  output logic            P2_SOURCE_ON,
  output logic            P2_SINK_ON,
  output logic            P2_RECIRC_ON,
  output logic            OVERCURRENT_GUARD,
  output logic            DRIVERS_ENABLED
);
  localparam int SW = 21;

  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  logic          step_s, dir_s, sel_lo_s, sel_hi_s, above_hi_s, below_lo_s;
  logic          clear_n_s, out_on_n_s, low_power_n_s, assist_off_s;
  logic          thermal_s, pump_low_s, sink_low_s, lockout_s, oc_s;
  logic          p1_trip_s, p2_trip_s, p1_node_s, p2_node_s, p1_zero_s, p2_zero_s;

  logic          step_d_r;
  logic          low_power_d_r;
  logic          step_rise;
  logic          wake_rise;
  logic          home_force;
  logic          step_take;
  logic [5:0]    inc;
  logic [5:0]    pos_r, pos_nxt;
  logic [4:0]    p1_lvl_nxt, p2_lvl_nxt;
  mst_decay_t    pfd_mode;
  logic          drv_en_nxt;
  logic [4:0]    oc_cnt_r;
  logic [15:0]   oc_left_r;

  assign raw = {STEP, DIR, RESOLUTION_SEL_LO, RESOLUTION_SEL_HI, DECAY_SEL_ABOVE_HI, DECAY_SEL_BELOW_LO,
                TRANSLATOR_CLEAR_N, OUTPUTS_ON_N, LOW_POWER_N, RECIRC_ASSIST_OFF, THERMAL_FAULT,
                GATE_PUMP_SUPPLY_LOW, SINK_GATE_SUPPLY_LOW, SUPPLY_LOW_LOCKOUT, OVERCURRENT_SENSE,
                P1_TRIP, P2_TRIP, P1_TIMING_NODE_AT_PFD, P2_TIMING_NODE_AT_PFD, P1_CURRENT_ZERO,
                P2_CURRENT_ZERO};

  mst_sync2 #(.W(SW)) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   (raw),
    .q   (syn)
  );

  assign {step_s, dir_s, sel_lo_s, sel_hi_s, above_hi_s, below_lo_s,
          clear_n_s, out_on_n_s, low_power_n_s, assist_off_s, thermal_s,
          pump_low_s, sink_low_s, lockout_s, oc_s,
          p1_trip_s, p2_trip_s, p1_node_s, p2_node_s, p1_zero_s, p2_zero_s} = syn;

  always_ff @(posedge CLK) begin
    if (RST) begin
      step_d_r      <= 1'b0;
      low_power_d_r <= 1'b0;
    end else begin
      step_d_r      <= step_s;
      low_power_d_r <= low_power_n_s;
    end
  end

  assign step_rise  = step_s && !step_d_r;
  assign wake_rise  = low_power_n_s && !low_power_d_r;
  assign home_force = !clear_n_s || lockout_s || wake_rise;
  // a sleeping translator has no supply, so steps then are dropped too
  assign step_take  = step_rise && !home_force && low_power_n_s;

  // resolution pins are looked at only when a step is taken
  always_comb begin
    case ({sel_hi_s, sel_lo_s})
      2'b00:   inc = `MST_INC_FULL;
      2'b01:   inc = `MST_INC_HALF;
      2'b10:   inc = `MST_INC_QUARTER;
      2'b11:   inc = `MST_INC_SIXTEENTH;
      default: inc = `MST_INC_FULL;
    endcase
  end

  // six-bit index wraps modulo 64 for free
  always_comb begin
    pos_nxt = pos_r;
    if (home_force)     pos_nxt = `MST_HOME_POS;
    else if (step_take) pos_nxt = dir_s ? pos_r + inc : pos_r - inc;
  end

  function automatic logic [4:0] cos_lvl(input logic [5:0] p);
    logic [4:0] r;
    r = {1'b0, p[3:0]};
    cos_lvl = p[4] ? r : `MST_LEVEL_MAX - r;
  endfunction

  function automatic logic [4:0] sin_lvl(input logic [5:0] p);
    logic [4:0] r;
    r = {1'b0, p[3:0]};
    sin_lvl = p[4] ? `MST_LEVEL_MAX - r : r;
  endfunction

  assign p1_lvl_nxt = cos_lvl(pos_nxt);
  assign p2_lvl_nxt = sin_lvl(pos_nxt);

  // the analog comparators already split the decay-select level at its two thresholds
  always_comb begin
    if (above_hi_s)      pfd_mode = DECAY_SLOW;
    else if (below_lo_s) pfd_mode = DECAY_FAST;
    else                 pfd_mode = DECAY_MIXED;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pos_r       <= `MST_HOME_POS;
      AT_ORIGIN_N <= 1'b0;
      P1_LEVEL    <= `MST_LEVEL_MAX >> 1;
      P2_LEVEL    <= `MST_LEVEL_MAX >> 1;
      P1_POSITIVE <= 1'b1;
      P2_POSITIVE <= 1'b1;
    end else begin
      pos_r       <= pos_nxt;
      AT_ORIGIN_N <= (pos_nxt != `MST_HOME_POS);
      P1_LEVEL    <= p1_lvl_nxt;
      P2_LEVEL    <= p2_lvl_nxt;
      P1_POSITIVE <= (pos_nxt[5] == pos_nxt[4]);
      P2_POSITIVE <= !pos_nxt[5];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      P1_DECAY <= DECAY_MIXED;
      P2_DECAY <= DECAY_MIXED;
    end else if (home_force) begin
      P1_DECAY <= DECAY_MIXED;
      P2_DECAY <= DECAY_MIXED;
    end else if (step_take) begin
      P1_DECAY <= (p1_lvl_nxt >= P1_LEVEL) ? DECAY_SLOW : pfd_mode;
      P2_DECAY <= (p2_lvl_nxt >= P2_LEVEL) ? DECAY_SLOW : pfd_mode;
    end
  end

  // counts consecutive over-threshold cycles; one clean cycle restarts the blank
  always_ff @(posedge CLK) begin
    if (RST) oc_cnt_r <= 5'h00;
    else if (!oc_s || OVERCURRENT_GUARD) oc_cnt_r <= 5'h00;
    else if (oc_cnt_r != 5'(`MST_OC_BLANK_CYC)) oc_cnt_r <= oc_cnt_r + 5'h01;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      OVERCURRENT_GUARD <= 1'b0;
      oc_left_r         <= 16'h0000;
    end else if (!OVERCURRENT_GUARD && oc_s && oc_cnt_r == 5'(`MST_OC_BLANK_CYC)) begin
      OVERCURRENT_GUARD <= 1'b1;
      oc_left_r         <= 16'(OC_LATCH_CYC - 1);
    end else if (OVERCURRENT_GUARD) begin
      if (oc_left_r == 16'h0000) OVERCURRENT_GUARD <= 1'b0;
      else oc_left_r <= oc_left_r - 16'h0001;
    end
  end

  assign drv_en_nxt = !out_on_n_s && low_power_n_s && clear_n_s && !thermal_s && !pump_low_s
                      && !sink_low_s && !lockout_s && !OVERCURRENT_GUARD;

  always_ff @(posedge CLK) begin
    if (RST) DRIVERS_ENABLED <= 1'b0;
    else     DRIVERS_ENABLED <= drv_en_nxt;
  end

  mst_phase_reg u_phase1 (
    .clk         (CLK),
    .rst         (RST),
    .enable      (DRIVERS_ENABLED),
    .decay       (P1_DECAY),
    .trip        (p1_trip_s),
    .node_at_pfd (p1_node_s),
    .cur_zero    (p1_zero_s),
    .assist_off  (assist_off_s),
    .src_on_r    (P1_SOURCE_ON),
    .snk_on_r    (P1_SINK_ON),
    .recirc_on_r (P1_RECIRC_ON)
  );

  mst_phase_reg u_phase2 (
    .clk         (CLK),
    .rst         (RST),
    .enable      (DRIVERS_ENABLED),
    .decay       (P2_DECAY),
    .trip        (p2_trip_s),
    .node_at_pfd (p2_node_s),
    .cur_zero    (p2_zero_s),
    .assist_off  (assist_off_s),
    .src_on_r    (P2_SOURCE_ON),
    .snk_on_r    (P2_SINK_ON),
    .recirc_on_r (P2_RECIRC_ON)
  );

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_take_full_fwd;
    step_take && !sel_hi_s && !sel_lo_s && dir_s;
  endsequence
  sequence s_take_fine_back;
    step_take && sel_hi_s && sel_lo_s && !dir_s;
  endsequence
  sequence s_clear_low;
    !clear_n_s;
  endsequence

  a_reset_home: assert property ($fell(RST) |-> pos_r == `MST_HOME_POS && P1_DECAY == DECAY_MIXED
                                && P2_DECAY == DECAY_MIXED && P1_POSITIVE && P2_POSITIVE)
    else $error("translator not at home with mixed decay after reset");
  a_step_full: assert property (s_take_full_fwd |=> pos_r == $past(pos_r) + 6'h10)
    else $error("full step forward did not move the index by sixteen");
  a_step_fine: assert property (s_take_fine_back |=> pos_r == $past(pos_r) - 6'h01)
    else $error("sixteenth step backward did not move the index by one");
  a_step_hold: assert property (!step_take && !home_force |=> $stable(pos_r) && $stable(P1_LEVEL))
    else $error("position changed without a step edge");
  a_origin_ind: assert property (AT_ORIGIN_N == (pos_r != `MST_HOME_POS))
    else $error("origin indicator disagrees with position");
  a_decay_up: assert property (step_take ##1 (P1_LEVEL >= $past(P1_LEVEL)) |-> P1_DECAY == DECAY_SLOW)
    else $error("rising phase level not in slow decay");
  a_decay_down: assert property (step_take ##1 (P2_LEVEL < $past(P2_LEVEL))
                                 |-> P2_DECAY == $past(pfd_mode))
    else $error("falling phase level not in the selected decay");
  a_clear_off: assert property (s_clear_low |=> pos_r == `MST_HOME_POS && !AT_ORIGIN_N
                                ##1 !P1_SOURCE_ON && !P1_SINK_ON && !P2_SOURCE_ON && !P2_SINK_ON)
    else $error("clear did not home the translator and stop the drivers");
  a_enable_off: assert property ((out_on_n_s || thermal_s || lockout_s)
                                 |-> ##2 !P1_SOURCE_ON && !P2_SOURCE_ON && !P1_SINK_ON && !P2_SINK_ON)
    else $error("outputs driven while disabled or faulted");
  a_wake_home: assert property (wake_rise |=> pos_r == `MST_HOME_POS)
    else $error("wake edge did not return the translator home");
  a_oc_latch: assert property (!OVERCURRENT_GUARD && oc_s && oc_cnt_r == 5'(`MST_OC_BLANK_CYC)
                               |=> OVERCURRENT_GUARD && oc_left_r == 16'(OC_LATCH_CYC - 1) ##1 !DRIVERS_ENABLED)
    else $error("sustained overcurrent did not latch the outputs off");
  a_oc_blank: assert property ($rose(oc_s) && !OVERCURRENT_GUARD |=> !OVERCURRENT_GUARD [*8])
    else $error("overcurrent latched inside its blank time");
endmodule

/* mst_translator_x.sv */
// holds no logic; kept empty on purpose

/* mst_host.sv */
// host model issuing advance pulses with minimum widths and the wake delay
`timescale 1ns/1ps
module mst_host (
  input  wire logic clk,
  input  wire logic low_power_n,
  output logic      step
);
  localparam int PULSE_CYC = 20;
  localparam int WAKE_CYC  = 20000;
  int   since_wake = WAKE_CYC;
  logic wake_q     = 1'b1;
  initial step = 1'b0;
  // counts cycles since the sleep input was released
  always @(posedge clk) begin
    wake_q <= low_power_n;
    if (low_power_n && !wake_q)
      since_wake <= 0;
    else if (since_wake < WAKE_CYC)
      since_wake <= since_wake + 1;
  end
  task automatic pulse();
    while (since_wake < WAKE_CYC) @(posedge clk);
    step <= 1'b1;
    repeat (PULSE_CYC) @(posedge clk);
    step <= 1'b0;
    repeat (PULSE_CYC) @(posedge clk);
  endtask
endmodule

/* testbench.sv */
// self-checking bench of the microstep translator driven by a host model
`timescale 1ns/1ps
`include "mst_params.svh"
module testbench import mst_pkg::*; ;
  logic CLK, RST, STEP, DIR, RESOLUTION_SEL_LO, RESOLUTION_SEL_HI, DECAY_SEL_ABOVE_HI, DECAY_SEL_BELOW_LO;
  logic TRANSLATOR_CLEAR_N, OUTPUTS_ON_N, LOW_POWER_N, RECIRC_ASSIST_OFF, THERMAL_FAULT;
  logic GATE_PUMP_SUPPLY_LOW, SINK_GATE_SUPPLY_LOW, SUPPLY_LOW_LOCKOUT, OVERCURRENT_SENSE;
  logic P1_TRIP, P2_TRIP, P1_TIMING_NODE_AT_PFD, P2_TIMING_NODE_AT_PFD, P1_CURRENT_ZERO, P2_CURRENT_ZERO;
  logic AT_ORIGIN_N, P1_POSITIVE, P2_POSITIVE, P1_SOURCE_ON, P1_SINK_ON, P1_RECIRC_ON;
  logic P2_SOURCE_ON, P2_SINK_ON, P2_RECIRC_ON, OVERCURRENT_GUARD, DRIVERS_ENABLED;
  logic [4:0] P1_LEVEL, P2_LEVEL;
  mst_decay_t P1_DECAY, P2_DECAY;
  logic [5:0] pos;
  int         fails;
  int         n_tests;
  int         n;

  mst_translator #(.OC_LATCH_CYC(50)) u_mst_translator (
    .CLK(CLK), .RST(RST), .STEP(STEP), .DIR(DIR), .RESOLUTION_SEL_LO(RESOLUTION_SEL_LO),
    .RESOLUTION_SEL_HI(RESOLUTION_SEL_HI), .DECAY_SEL_ABOVE_HI(DECAY_SEL_ABOVE_HI),
    .DECAY_SEL_BELOW_LO(DECAY_SEL_BELOW_LO), .TRANSLATOR_CLEAR_N(TRANSLATOR_CLEAR_N),
    .OUTPUTS_ON_N(OUTPUTS_ON_N), .LOW_POWER_N(LOW_POWER_N), .RECIRC_ASSIST_OFF(RECIRC_ASSIST_OFF),
    .THERMAL_FAULT(THERMAL_FAULT), .GATE_PUMP_SUPPLY_LOW(GATE_PUMP_SUPPLY_LOW),
    .SINK_GATE_SUPPLY_LOW(SINK_GATE_SUPPLY_LOW), .SUPPLY_LOW_LOCKOUT(SUPPLY_LOW_LOCKOUT),
    .OVERCURRENT_SENSE(OVERCURRENT_SENSE), .P1_TRIP(P1_TRIP), .P2_TRIP(P2_TRIP),
    .P1_TIMING_NODE_AT_PFD(P1_TIMING_NODE_AT_PFD), .P2_TIMING_NODE_AT_PFD(P2_TIMING_NODE_AT_PFD),
    .P1_CURRENT_ZERO(P1_CURRENT_ZERO), .P2_CURRENT_ZERO(P2_CURRENT_ZERO), .AT_ORIGIN_N(AT_ORIGIN_N),
    .P1_LEVEL(P1_LEVEL), .P1_POSITIVE(P1_POSITIVE), .P2_LEVEL(P2_LEVEL), .P2_POSITIVE(P2_POSITIVE),
    .P1_DECAY(P1_DECAY), .P2_DECAY(P2_DECAY), .P1_SOURCE_ON(P1_SOURCE_ON), .P1_SINK_ON(P1_SINK_ON),
    .P1_RECIRC_ON(P1_RECIRC_ON), .P2_SOURCE_ON(P2_SOURCE_ON), .P2_SINK_ON(P2_SINK_ON),
    .P2_RECIRC_ON(P2_RECIRC_ON), .OVERCURRENT_GUARD(OVERCURRENT_GUARD), .DRIVERS_ENABLED(DRIVERS_ENABLED)
  );
  mst_host u_mst_host (.clk(CLK), .low_power_n(LOW_POWER_N), .step(STEP));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
  endtask
  task automatic chk(input logic [4:0] g, input logic [4:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // s=0 gives the cosine phase, s=1 the sine phase
  function automatic logic [4:0] lv(input logic [5:0] p, input logic s);
    if (p[4] ^ s)
      return {1'b0, p[3:0]};
    return `MST_LEVEL_MAX - {1'b0, p[3:0]};
  endfunction
  function automatic mst_decay_t dec(input logic [4:0] nw, input logic [4:0] od, input logic [1:0] ds);
    if (nw >= od || ds[1])
      return DECAY_SLOW;
    if (ds[0])
      return DECAY_FAST;
    return DECAY_MIXED;
  endfunction
  task automatic chk_pos();
    chk(P1_LEVEL, lv(pos, 1'b0), "phase 1 level");
    chk(P2_LEVEL, lv(pos, 1'b1), "phase 2 level");
    chk(5'(P1_POSITIVE), 5'(pos[5] == pos[4]), "phase 1 sign");
    chk(5'(P2_POSITIVE), 5'(!pos[5]), "phase 2 sign");
    chk(5'(AT_ORIGIN_N), 5'(pos != `MST_HOME_POS), "origin flag");
  endtask
  task automatic chk_off(input string m);
    chk(5'(DRIVERS_ENABLED), 5'h00, m);
    chk(5'(P1_SOURCE_ON | P1_SINK_ON | P2_SOURCE_ON | P2_SINK_ON), 5'h00, m);
  endtask
  task automatic adv(input logic d, input logic [1:0] res, input logic [1:0] ds);
    logic [5:0] inc;
    logic [4:0] o1;
    logic [4:0] o2;
    @(posedge CLK);
    DIR <= d;
    {RESOLUTION_SEL_HI, RESOLUTION_SEL_LO} <= res;
    {DECAY_SEL_ABOVE_HI, DECAY_SEL_BELOW_LO} <= ds;
    cyc(4);
    chk_pos();
    o1 = lv(pos, 1'b0);
    o2 = lv(pos, 1'b1);
    inc = res == 2'h0 ? `MST_INC_FULL : res == 2'h1 ? `MST_INC_HALF : res == 2'h2 ? `MST_INC_QUARTER
        : `MST_INC_SIXTEENTH;
    u_mst_host.pulse();
    pos = d ? pos + inc : pos - inc;
    chk_pos();
    chk(5'(P1_DECAY), 5'(dec(lv(pos, 1'b0), o1, ds)), "phase 1 decay");
    chk(5'(P2_DECAY), 5'(dec(lv(pos, 1'b1), o2, ds)), "phase 2 decay");
  endtask

  initial begin
    {RST, TRANSLATOR_CLEAR_N, LOW_POWER_N} = 3'h7;
    {DIR, RESOLUTION_SEL_LO, RESOLUTION_SEL_HI, DECAY_SEL_ABOVE_HI, DECAY_SEL_BELOW_LO} = 5'h00;
    {OUTPUTS_ON_N, RECIRC_ASSIST_OFF, THERMAL_FAULT, GATE_PUMP_SUPPLY_LOW, SINK_GATE_SUPPLY_LOW} = 5'h00;
    {SUPPLY_LOW_LOCKOUT, OVERCURRENT_SENSE, P1_TRIP, P2_TRIP} = 4'h0;
    {P1_TIMING_NODE_AT_PFD, P2_TIMING_NODE_AT_PFD, P1_CURRENT_ZERO, P2_CURRENT_ZERO} = 4'h0;
    fails = 0;
    n_tests = 0;
    pos = `MST_HOME_POS;
    cyc(3);
    RST <= 1'b0;
    cyc(6);
    chk_pos();
    chk(5'(P1_DECAY), 5'(DECAY_MIXED), "reset decay");
    chk(5'(P2_DECAY), 5'(DECAY_MIXED), "reset decay");
    chk(5'(DRIVERS_ENABLED), 5'h01, "drivers on");
    // three steps forward then three back in every resolution, decay select rotating
    for (int r = 0; r < 4; r++)
      for (int k = 0; k < 6; k++)
        adv(k < 3, 2'(r), 2'(k % 3));
    adv(1'b1, 2'h3, 2'h0);
    TRANSLATOR_CLEAR_N <= 1'b0;
    cyc(5);
    u_mst_host.pulse();
    pos = `MST_HOME_POS;
    chk_pos();
    chk_off("clear");
    chk(5'(P1_DECAY), 5'(DECAY_MIXED), "clear decay");
    TRANSLATOR_CLEAR_N <= 1'b1;
    cyc(5);
    OUTPUTS_ON_N <= 1'b1;
    cyc(5);
    chk_off("disabled");
    adv(1'b0, 2'h1, 2'h2);
    OUTPUTS_ON_N <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      cyc(5);
      {THERMAL_FAULT, GATE_PUMP_SUPPLY_LOW, SINK_GATE_SUPPLY_LOW} <= 3'(1 << i);
      cyc(5);
      chk_off("fault");
      {THERMAL_FAULT, GATE_PUMP_SUPPLY_LOW, SINK_GATE_SUPPLY_LOW} <= 3'h0;
      cyc(5);
      chk(5'(DRIVERS_ENABLED), 5'h01, "fault cleared");
    end
    SUPPLY_LOW_LOCKOUT <= 1'b1;
    cyc(5);
    u_mst_host.pulse();
    pos = `MST_HOME_POS;
    chk_pos();
    chk_off("lockout");
    SUPPLY_LOW_LOCKOUT <= 1'b0;
    adv(1'b1, 2'h2, 2'h1);
    LOW_POWER_N <= 1'b0;
    cyc(5);
    chk_off("sleep");
    chk_pos();
    LOW_POWER_N <= 1'b1;
    cyc(5);
    pos = `MST_HOME_POS;
    chk_pos();
    adv(1'b1, 2'h3, 2'h0);
    // regulator: home force leaves both bridges in mixed decay
    TRANSLATOR_CLEAR_N <= 1'b0;
    cyc(5);
    TRANSLATOR_CLEAR_N <= 1'b1;
    pos = `MST_HOME_POS;
    cyc(40);
    chk(5'({P1_SOURCE_ON, P1_SINK_ON}), 5'h03, "on phase");
    P1_TRIP <= 1'b1;
    P2_TRIP <= 1'b1;
    cyc(5);
    chk(5'({P1_SOURCE_ON, P1_SINK_ON, P1_RECIRC_ON}), 5'h01, "mixed fast part");
    // assistance is shared by both bridges, so phase 2 shows it being turned off
    P1_CURRENT_ZERO <= 1'b1;
    RECIRC_ASSIST_OFF <= 1'b1;
    cyc(4);
    chk(5'(P1_RECIRC_ON), 5'h00, "zero current");
    chk(5'({P2_SOURCE_ON, P2_RECIRC_ON}), 5'h00, "assist off");
    P1_TIMING_NODE_AT_PFD <= 1'b1;
    cyc(4);
    chk(5'({P1_SOURCE_ON, P1_SINK_ON}), 5'h01, "mixed slow part");
    {P1_TRIP, P2_TRIP, P1_TIMING_NODE_AT_PFD, P1_CURRENT_ZERO, RECIRC_ASSIST_OFF} <= 5'h00;
    n = 13;
    while (P1_SOURCE_ON !== 1'b1 && n < 900) begin
      cyc(1);
      n++;
    end
    chk(5'(n >= 760 && n <= 768), 5'h01, "off time");
    P1_TRIP <= 1'b1;
    cyc(4);
    P1_TRIP <= 1'b0;
    cyc(3);
    chk(5'({P1_SOURCE_ON, P1_SINK_ON}), 5'h03, "blanked trip");
    OVERCURRENT_SENSE <= 1'b1;
    cyc(20);
    OVERCURRENT_SENSE <= 1'b0;
    cyc(3);
    chk(5'(OVERCURRENT_GUARD), 5'h00, "short overcurrent");
    OVERCURRENT_SENSE <= 1'b1;
    cyc(40);
    OVERCURRENT_SENSE <= 1'b0;
    chk(5'(OVERCURRENT_GUARD), 5'h01, "latch off");
    chk(5'(P1_SOURCE_ON | P2_SOURCE_ON | P1_SINK_ON | P2_SINK_ON), 5'h00, "latched drives");
    cyc(60);
    chk(5'(OVERCURRENT_GUARD), 5'h00, "latch end");
    test_done();
  end

  // normal run is about 22000 cycles
  initial begin
    cyc(60000);
    fails++;
    test_done();
  end
endmodule
